// [design/rcs_sequencer.v]
`timescale 1ns/1ps
`include "rcs_regs.vh"

module rcs_sequencer #(
	parameter SETTLE_CYCLES = `RCS_SETTLE_CYCLES,
	parameter SYSCLK_PER_MC = `RCS_SYSCLK_PER_MC
) (
	input  wire       i_clock,
	input  wire       i_reset,
	input  wire       i_reset_pin,
	input  wire       i_supply_ok,
	input  wire       i_osc_input_pin,
	input  wire       i_power_down_req,
	input  wire       i_wdt_ctrl_we,
	input  wire [7:0] i_wdt_ctrl_wdata,
	input  wire       i_wdt_clear,
	output wire       o_internal_reset_signal,
	output wire       o_por_reset,
	output wire       o_wdt_reset,
	output wire       o_cpu_clock_en,
	output wire       o_sys_clock,
	output wire       o_osc_output_pin,
	output wire       o_osc_output_oe_n,
	output wire       o_osc_amp_en,
	output wire       o_power_down,
	output wire [7:0] o_port_reset_value,
	output wire [7:0] o_stack_pointer,
	output wire [7:0] o_busy_watchdog_control,
	output wire [7:0] o_watchdog_counter
);
	// ----------------------------------------------------------------
	// Derived counts
	// ----------------------------------------------------------------
	localparam HOLD_CYCLES = `RCS_POR_HOLD_NS / `RCS_CLOCK_PERIOD_NS;
	// Response is counted from the supply pin, so the synchroniser delay is taken off
	localparam SYNC_LAT    = 4;
	localparam RESP_CYCLES = `RCS_POR_RESP_NS / `RCS_CLOCK_PERIOD_NS - SYNC_LAT;
	localparam WDT_CYCLES  = `RCS_WDT_PULSE_MC * SYSCLK_PER_MC;

	localparam ST_RESET  = 2'b00;
	localparam ST_SETTLE = 2'b01;
	localparam ST_RUN    = 2'b10;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	wire pin_sync;
	wire supply_sync;
	wire osc_sync;

	rcs_sync #(.RESET_VALUE(1'b1)) u_pin_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (i_reset_pin),
		.o_sync  (pin_sync)
	);

	rcs_sync #(.RESET_VALUE(1'b0)) u_supply_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (i_supply_ok),
		.o_sync  (supply_sync)
	);

	rcs_sync #(.RESET_VALUE(1'b0)) u_osc_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_async (i_osc_input_pin),
		.o_sync  (osc_sync)
	);

	// ----------------------------------------------------------------
	// Power-on reset
	// ----------------------------------------------------------------
	reg        por_reg;
	reg [15:0] hold_cnt_reg;
	reg [15:0] resp_cnt_reg;

	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			por_reg      <= 1'b1;
			hold_cnt_reg <= 16'h0000;
			resp_cnt_reg <= 16'h0000;
		end else if (!supply_sync) begin
			hold_cnt_reg <= 16'h0000;
			if (por_reg || resp_cnt_reg >= RESP_CYCLES[15:0] - 16'h0001)
				por_reg <= 1'b1;
			else
				resp_cnt_reg <= resp_cnt_reg + 16'h0001;
		end else begin
			resp_cnt_reg <= 16'h0000;
			if (por_reg) begin
				if (hold_cnt_reg >= HOLD_CYCLES[15:0] - 16'h0001)
					por_reg <= 1'b0;
				else
					hold_cnt_reg <= hold_cnt_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	reg  [7:0] wdt_ctrl_reg;
	reg  [7:0] wdt_cnt_reg;
	reg  [3:0] mc_cnt_reg;
	reg  [7:0] wdt_pulse_reg;
	wire       wdt_en  = wdt_ctrl_reg[`RCS_WDT_EN_BIT];
	wire       wdt_act = (wdt_pulse_reg != 8'h00);
	wire       int_rst;

	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wdt_ctrl_reg  <= `RCS_WDT_CTRL_RESET;
			wdt_cnt_reg   <= `RCS_ZERO_RESET;
			mc_cnt_reg    <= 4'h0;
			wdt_pulse_reg <= 8'h00;
		end else begin
			if (wdt_act)
				wdt_pulse_reg <= wdt_pulse_reg - 8'h01;
			if (int_rst) begin
				wdt_ctrl_reg <= `RCS_WDT_CTRL_RESET;
				wdt_cnt_reg  <= `RCS_ZERO_RESET;
				mc_cnt_reg   <= 4'h0;
			end else begin
				if (i_wdt_ctrl_we)
					wdt_ctrl_reg <= i_wdt_ctrl_wdata;
				if (mc_cnt_reg == SYSCLK_PER_MC[3:0] - 4'h1)
					mc_cnt_reg <= 4'h0;
				else
					mc_cnt_reg <= mc_cnt_reg + 4'h1;
				if (i_wdt_clear || !wdt_en)
					wdt_cnt_reg <= `RCS_ZERO_RESET;
				else if (mc_cnt_reg == SYSCLK_PER_MC[3:0] - 4'h1) begin
					if (wdt_cnt_reg == `RCS_WDT_MAX) begin
						wdt_cnt_reg   <= `RCS_ZERO_RESET;
						wdt_pulse_reg <= WDT_CYCLES[7:0];
					end else
						wdt_cnt_reg <= wdt_cnt_reg + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset combine and clock settling
	// ----------------------------------------------------------------
	assign int_rst = pin_sync || por_reg || wdt_act;

	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [11:0] settle_reg;

	always @* begin
		case (state_reg)
			ST_RESET:  state_next = int_rst ? ST_RESET : ST_SETTLE;
			ST_SETTLE: begin
				if (int_rst)
					state_next = ST_RESET;
				else if (settle_reg == SETTLE_CYCLES[11:0] - 12'h001)
					state_next = ST_RUN;
				else
					state_next = ST_SETTLE;
			end
			ST_RUN:    state_next = int_rst ? ST_RESET : ST_RUN;
			default:   state_next = ST_RESET;
		endcase
	end

	// ----------------------------------------------------------------
	// Clock divider, settle counter and power-down
	// ----------------------------------------------------------------
	reg osc_prev_reg;
	reg div_reg;
	reg pd_reg;

	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_reg    <= ST_RESET;
			settle_reg   <= 12'h000;
			osc_prev_reg <= 1'b0;
			div_reg      <= 1'b0;
			pd_reg       <= 1'b0;
		end else begin
			state_reg    <= state_next;
			osc_prev_reg <= osc_sync;
			if (osc_sync && !osc_prev_reg && !pd_reg)
				div_reg <= ~div_reg;
			if (state_reg == ST_SETTLE && state_next == ST_SETTLE)
				settle_reg <= settle_reg + 12'h001;
			else
				settle_reg <= 12'h000;
			if (int_rst)
				pd_reg <= 1'b0;
			else if (i_power_down_req && !wdt_en && state_reg == ST_RUN)
				pd_reg <= 1'b1;
		end
	end

	assign o_internal_reset_signal = int_rst;
	assign o_por_reset             = por_reg;
	assign o_wdt_reset             = wdt_act;
	assign o_cpu_clock_en          = (state_reg == ST_RUN) && !pd_reg;
	assign o_sys_clock             = div_reg;
	assign o_osc_output_pin        = 1'b1;
	assign o_osc_output_oe_n       = ~pd_reg;
	assign o_osc_amp_en            = ~pd_reg;
	assign o_power_down            = pd_reg;
	// reset values for the CPU; RAM has no reset here
	assign o_port_reset_value      = `RCS_PORT_RESET;
	assign o_stack_pointer         = `RCS_SP_RESET;
	assign o_busy_watchdog_control = wdt_ctrl_reg;
	assign o_watchdog_counter      = wdt_cnt_reg;
endmodule

// [design/rcs_regs.vh]
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RCS_OSC_FREQ_MHZ     12
`define RCS_CLOCK_PERIOD_NS  4
`define RCS_SYSCLK_PER_MC    12
`define RCS_EXT_RESET_MC     2
`define RCS_WDT_PULSE_MC     3
`define RCS_SETTLE_CYCLES    2048
`define RCS_POR_HOLD_NS      1000
`define RCS_POR_RESP_NS      100

// ----------------------------------------------------------------
// Reset values of CPU registers, watchdog enable bit and watchdog maximum count
// ----------------------------------------------------------------
`define RCS_PORT_RESET       8'hFF
`define RCS_SP_RESET         8'h07
`define RCS_ZERO_RESET       8'h00
`define RCS_WDT_EN_BIT       1
`define RCS_WDT_CTRL_RESET   8'h02
`define RCS_WDT_MAX          8'hFF

`endif

// [design/rcs_sync.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Three-stage input synchroniser, change taken when stages 2 and 3 agree
// ----------------------------------------------------------------
module rcs_sync #(
	parameter RESET_VALUE = 1'b0
) (
	input  wire i_clock,
	input  wire i_reset,
	input  wire i_async,
	output wire o_sync
);
	reg  [2:0] stage_reg;
	reg        level_reg;

	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			stage_reg <= {3{RESET_VALUE[0]}};
			level_reg <= RESET_VALUE[0];
		end else begin
			stage_reg <= {stage_reg[1:0], i_async};
			if (stage_reg[1] == stage_reg[2])
				level_reg <= stage_reg[2];
		end
	end

	assign o_sync = level_reg;
endmodule

// [bench/rcs_checker.sv]
`timescale 1ns/1ps
module rcs_checker #(
	parameter SETTLE_CYCLES = 16
) (
	input wire       i_clock,
	input wire       i_reset,
	input wire       o_internal_reset_signal,
	input wire       o_por_reset,
	input wire       o_wdt_reset,
	input wire       o_cpu_clock_en,
	input wire       o_power_down,
	input wire       o_osc_output_pin,
	input wire       o_osc_output_oe_n,
	input wire       o_osc_amp_en,
	input wire [7:0] o_busy_watchdog_control
);
	localparam int PULSE = 36;
	reg [15:0] wd_reg;
	reg [15:0] st_reg;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// ------------------------------------------------
	// Pulse and settle lengths
	// ------------------------------------------------
	always @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wd_reg <= 16'h0000;
			st_reg <= 16'h0000;
		end else begin
			wd_reg <= o_wdt_reset ? wd_reg + 16'h0001 : 16'h0000;
			st_reg <= o_internal_reset_signal ? 16'h0000 : st_reg + 16'h0001;
		end
	end
	por_joins_a: assert property (o_por_reset |-> o_internal_reset_signal)
		else $error("power-on reset not in internal reset");
	wdt_joins_a: assert property (o_wdt_reset |-> o_internal_reset_signal)
		else $error("watchdog pulse not in internal reset");
	reset_gates_a: assert property (o_internal_reset_signal [*2] |-> !o_cpu_clock_en)
		else $error("cpu clock runs in reset");
	settle_len_a: assert property ($rose(o_cpu_clock_en) |->
		st_reg >= SETTLE_CYCLES && st_reg <= SETTLE_CYCLES + 2)
		else $error("settle count wrong");
	settle_hold_a: assert property ($fell(o_internal_reset_signal) |=> !o_cpu_clock_en [*8])
		else $error("cpu clock released early");
	pulse_len_a: assert property ($fell(o_wdt_reset) |-> wd_reg == PULSE)
		else $error("watchdog pulse length wrong");
	pd_pins_a: assert property (o_power_down |->
		o_osc_output_pin && !o_osc_output_oe_n && !o_osc_amp_en)
		else $error("oscillator pins wrong in power-down");
	pd_refused_a: assert property ($rose(o_power_down) |-> !$past(o_busy_watchdog_control[1]))
		else $error("power-down entered with watchdog on");
	cover property ($rose(o_cpu_clock_en));
	cover property ($fell(o_wdt_reset));
	cover property ($rose(o_power_down));
endmodule
bind rcs_sequencer rcs_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (.i_clock(i_clock),
	.i_reset(i_reset), .o_internal_reset_signal(o_internal_reset_signal),
	.o_por_reset(o_por_reset), .o_wdt_reset(o_wdt_reset), .o_cpu_clock_en(o_cpu_clock_en),
	.o_power_down(o_power_down), .o_osc_output_pin(o_osc_output_pin),
	.o_osc_output_oe_n(o_osc_output_oe_n), .o_osc_amp_en(o_osc_amp_en),
	.o_busy_watchdog_control(o_busy_watchdog_control));

// [bench/rcs_board_model.sv]
`timescale 1ns/1ps
module rcs_board_model (
	input  wire i_clock,
	input  wire i_power_down,
	input  wire i_pulse_req,
	output reg  o_osc,
	output reg  o_pin
);
	initial begin
		o_osc = 1'b0;
		o_pin = 1'b0;
	end
	// Crystal stops and is pulled high in power-down
	always #41.667 o_osc = i_power_down ? 1'b1 : ~o_osc;
	// Reset pin held for two machine cycles of the crystal
	always @(posedge i_clock) if (i_pulse_req) begin
		@(negedge i_clock);
		o_pin = 1'b1;
		repeat (24) @(posedge o_osc);
		@(negedge i_clock);
		o_pin = 1'b0;
	end
endmodule

// [bench/test_rcs_sequencer.sv]
`timescale 1ns/1ps
module test_rcs_sequencer;
	reg i_clock = 1'b0;
	reg i_reset = 1'b1;
	reg i_supply_ok = 1'b0;
	reg i_power_down_req = 1'b0;
	reg i_wdt_ctrl_we = 1'b0;
	reg i_wdt_clear = 1'b0;
	reg pin_req = 1'b0;
	reg en_d = 1'b0;
	reg s;
	reg [7:0] i_wdt_ctrl_wdata = 8'h00;
	reg [31:0] seed = 99;
	wire i_reset_pin, i_osc_input_pin, rst, por, wdt, en, sclk, opin, oe_n, amp, pd;
	wire [7:0] port_v, sp, ctrl, wcnt;
	integer fails = 0, checks = 0, settle = 0, i, n, t, e;
	integer exp_q[$];
	always #2 i_clock = ~i_clock;
	rcs_sequencer #(.SETTLE_CYCLES(16)) i_dut (.i_clock(i_clock), .i_reset(i_reset),
		.i_reset_pin(i_reset_pin), .i_supply_ok(i_supply_ok), .i_osc_input_pin(i_osc_input_pin),
		.i_power_down_req(i_power_down_req), .i_wdt_ctrl_we(i_wdt_ctrl_we),
		.i_wdt_ctrl_wdata(i_wdt_ctrl_wdata), .i_wdt_clear(i_wdt_clear),
		.o_internal_reset_signal(rst), .o_por_reset(por), .o_wdt_reset(wdt),
		.o_cpu_clock_en(en), .o_sys_clock(sclk), .o_osc_output_pin(opin),
		.o_osc_output_oe_n(oe_n), .o_osc_amp_en(amp), .o_power_down(pd),
		.o_port_reset_value(port_v), .o_stack_pointer(sp),
		.o_busy_watchdog_control(ctrl), .o_watchdog_counter(wcnt));
	rcs_board_model i_board (.i_clock(i_clock), .i_power_down(pd), .i_pulse_req(pin_req),
		.o_osc(i_osc_input_pin), .o_pin(i_reset_pin));
	function [31:0] xs(input [31:0] v);
		xs = v ^ (v << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	task check(input [63:0] what, input [31:0] seen, input [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("mismatch %0s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task summarize;
		if (fails == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge i_clock);
	endtask
	task wt(input sel, input v, input integer lim);
		for (n = 0; (sel ? por : rst) !== v && n < lim; n = n + 1) cyc(1);
		if ((sel ? por : rst) !== v) fails = fails + 1;
	endtask
	task clr;
		i_wdt_clear = 1'b1;
		cyc(1);
		i_wdt_clear = 1'b0;
	endtask
	// ------------------------------------------------
	// Settle monitor, one note per clock release
	// ------------------------------------------------
	always @(negedge i_clock) begin
		if (rst !== 1'b0) settle = 0;
		else if (en !== 1'b1) settle = settle + 1;
		else if (en_d === 1'b0) begin
			e = exp_q.size() ? exp_q.pop_front() : -9;
			check("settle", settle >= e && settle <= e + 2, 1);
		end
		en_d = en;
	end
	initial begin
		#200000;
		fails = fails + 1;
		summarize;
	end
	initial begin
		cyc(4);
		i_reset = 1'b0;
		check("port", port_v, 8'hFF);
		check("sp", sp, 8'h07);
		check("ctrl", ctrl, 8'h02);
		exp_q.push_back(16);
		i_supply_ok = 1'b1;
		wt(1, 0, 400);
		check("hold", n >= 250 && n <= 256, 1);
		for (i = 0; i < 3; i = i + 1) begin
			clr;
			wt(0, 0, 700);
			seed = xs(seed);
			cyc(seed % 12);
			pin_req = 1'b1;
			cyc(1);
			pin_req = 1'b0;
			wt(0, 1, 8);
			check("pin", rst, 1);
		end
		clr;
		wt(0, 0, 700);
		cyc(30);
		check("run", en, 1);
		i_supply_ok = 1'b0;
		wt(0, 1, 30);
		check("drop", n <= 25 && rst === 1'b1, 1);
		cyc(10);
		exp_q.push_back(16);
		i_supply_ok = 1'b1;
		wt(1, 0, 400);
		check("rehold", n >= 250 && n <= 256, 1);
		clr;
		s = sclk;
		t = 0;
		for (i = 0; i < 840; i = i + 1) begin
			cyc(1);
			t = t + (sclk !== s);
			s = sclk;
		end
		check("div", t >= 39 && t <= 41, 1);
		clr;
		cyc(2);
		check("wcnt", wcnt, 8'h00);
		exp_q.push_back(16);
		wt(0, 1, 3300);
		check("wdt", wdt === 1'b1 && n >= 3050 && n <= 3090, 1);
		cyc(80);
		check("rerun", en, 1);
		i_power_down_req = 1'b1;
		cyc(10);
		check("pdref", pd, 0);
		i_power_down_req = 1'b0;
		i_wdt_ctrl_wdata = xs(seed) & 8'hFD;
		i_wdt_ctrl_we = 1'b1;
		cyc(1);
		i_wdt_ctrl_we = 1'b0;
		i_power_down_req = 1'b1;
		cyc(10);
		check("pd", pd, 1);
		check("amp", {amp, oe_n, opin}, 3'h1);
		check("left", exp_q.size(), 0);
		summarize;
	end
endmodule
